// *** rtl/cc_sink_detect.sv ***
`timescale 1ns/1ps
module cc_sink_detect
   import usb_detect_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = usb_detect_pkg::CC_DEB_CYCLES
) (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire logic                       enable,
   input  wire usb_detect_pkg::cc_level_t  cc1,
   input  wire usb_detect_pkg::cc_level_t  cc2,
   output      logic                       attached,
   output      logic                       active_line,
   output      usb_detect_pkg::limit_t     limit
);
   import usb_detect_pkg::*;

   typedef struct packed {
      cc_level_t            cand_lvl;
      logic                 cand_line;
      logic [TIMER_W-1:0]   timer;
      logic                 attached;
      logic                 active;
      limit_t               limit;
   } cc_state_t;

   cc_state_t cur;
   cc_state_t next_cur;
   cc_level_t obs_lvl;
   logic      obs_line;

   // -----------------------------------------------------------------
   // attach, line selection and level tracking
   // -----------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      // once attached only the active line is watched; the other carries vconn
      if (cur.attached) begin
         obs_line = cur.active;
         obs_lvl  = cur.active ? cc2 : cc1;
      end else if (cc1 != CC_OPEN) begin
         obs_line = 1'b0;
         obs_lvl  = cc1;
      end else begin
         obs_line = (cc2 != CC_OPEN);
         obs_lvl  = cc2;
      end
      if (!enable) begin
         next_cur = '0;
      end else if ({obs_line, obs_lvl} != {cur.cand_line, cur.cand_lvl}) begin
         next_cur.cand_line = obs_line;
         next_cur.cand_lvl  = obs_lvl;
         next_cur.timer     = TIMER_W'(DEB_CYCLES - 1);
      end else if (cur.timer != '0) begin
         next_cur.timer = cur.timer - 1'b1;
      end else if (cur.cand_lvl == CC_OPEN) begin
         next_cur.attached = 1'b0;
         next_cur.limit    = LIM_NONE;
      end else begin
         next_cur.attached = 1'b1;
         next_cur.active   = cur.cand_line;
         next_cur.limit    = cc_limit(cur.cand_lvl);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign attached    = cur.attached;
   assign active_line = cur.active;
   assign limit       = cur.limit;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_cc_disabled;
      !enable |=> !attached && limit == LIM_NONE;
   endproperty
   a_cc_disabled: assert property (p_cc_disabled) else $error("cc state kept while disabled");

   property p_cc_decode;
      attached |-> limit == LIM_500 || limit == LIM_1500 || limit == LIM_3000;
   endproperty
   a_cc_decode: assert property (p_cc_decode) else $error("cc limit not a legal level");

   property p_cc_update;
      enable && cur.timer == '0 && cur.cand_lvl != CC_OPEN
         && {obs_line, obs_lvl} == {cur.cand_line, cur.cand_lvl}
      |=> limit == cc_limit($past(cur.cand_lvl)) && attached;
   endproperty
   a_cc_update: assert property (p_cc_update) else $error("cc limit not updated");

   property p_cc_active;
      $rose(attached) |-> active_line == $past(cur.cand_line);
   endproperty
   a_cc_active: assert property (p_cc_active) else $error("wrong active cc line");

endmodule

// *** rtl/usb_charger_type_detect.sv ***
`timescale 1ns/1ps
// Functional notes
// - bc1.2 sequence classifies sdp, cdp or dcp
// - proprietary signatures reported in separate field
// - open data lines report as sdp
// - unrecognised source gets 500 ma limit
// - sdp or none 500 ma, cdp/dcp 1.5 a
// - proprietary limits 0.5/1/2/2.4, 2, 3 a
// - applied usb limit shown in status field
// - after detection apply highest supported limit
// - data-line detection off when its enable low
// - sink picks the active cc line
// - advertised cc level decodes to 0.5/1.5/3 a
// - cc level change updates limit automatically
// - cc derived current shown in own field
// - cc detection off when its enable low
// - both detectors parallel, larger limit applied
module usb_charger_type_detect
   import usb_detect_pkg::*;
#(
   parameter int unsigned DCD_CYC    = usb_detect_pkg::DCD_CYCLES,
   parameter int unsigned SETTLE_CYC = usb_detect_pkg::SETTLE_CYCLES,
   parameter int unsigned CC_DEB_CYC = usb_detect_pkg::CC_DEB_CYCLES
) (
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   input  wire logic                         dpdm_detect_enable,
   input  wire logic                         cc_detect_enable,
   input  wire usb_detect_pkg::front_end_t   front_end,
   output      logic                         dp_source_on,
   output      logic                         dm_source_on,
   output      logic                         dcd_current_on,
   output      logic                         detect_done,
   output      usb_detect_pkg::port_class_t  bc12_port_class_field,
   output      usb_detect_pkg::prop_class_t  proprietary_class_field,
   output      usb_detect_pkg::limit_t       usb_applied_limit_field,
   output      usb_detect_pkg::limit_t       cc_current_field,
   output      logic                         cc_attached,
   output      logic                         cc_active_line
);
   import usb_detect_pkg::*;

   typedef struct packed {
      front_end_t           sync1;
      front_end_t           sync2;
      bc_state_t            state;
      logic [TIMER_W-1:0]   timer;
      port_class_t          port_class;
      prop_class_t          prop_class;
      limit_t               dpdm_limit;
      limit_t               applied;
      logic                 dp_src;
      logic                 dm_src;
      logic                 dcd_src;
      logic                 done;
   } top_state_t;

   top_state_t cur;
   top_state_t next_cur;
   front_end_t fe;
   limit_t     cc_lim;
   limit_t     dpdm_eff;
   logic       cc_att;
   logic       cc_line;

   // -----------------------------------------------------------------
   // type-c sink detector
   // -----------------------------------------------------------------
   cc_sink_detect #(
      .DEB_CYCLES (CC_DEB_CYC)
   ) u_cc (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .enable      (cc_detect_enable),
      .cc1         (cur.sync2.cc1),
      .cc2         (cur.sync2.cc2),
      .attached    (cc_att),
      .active_line (cc_line),
      .limit       (cc_lim)
   );

   // -----------------------------------------------------------------
   // data-line detection and limit selection
   // -----------------------------------------------------------------
   always_comb begin
      next_cur       = cur;
      next_cur.sync1 = front_end;
      next_cur.sync2 = cur.sync1;
      fe             = cur.sync2;
      if (cur.timer != '0) begin
         next_cur.timer = cur.timer - 1'b1;
      end
      unique case (cur.state)
         BC_IDLE: begin
            if (dpdm_detect_enable && fe.supply_ok) begin
               next_cur.state   = BC_CONTACT;
               next_cur.dcd_src = 1'b1;
               next_cur.timer   = TIMER_W'(DCD_CYC - 1);
            end
         end
         BC_CONTACT: begin
            // a pulled-down d+ under the contact current means the plug is seated;
            // the first samples predate that current, having crossed the synchroniser
            if (!fe.dp_high && cur.timer < TIMER_W'(DCD_CYC - SYNC_STAGES)) begin
               next_cur.state   = BC_PRIMARY;
               next_cur.dcd_src = 1'b0;
               next_cur.dp_src  = 1'b1;
               next_cur.timer   = TIMER_W'(SETTLE_CYC - 1);
            end else if (cur.timer == '0) begin
               next_cur.state      = BC_DONE;
               next_cur.dcd_src    = 1'b0;
               next_cur.port_class = PORT_SDP;
               next_cur.dpdm_limit = bc_limit(PORT_SDP);
            end
         end
         BC_PRIMARY: begin
            if (cur.timer == '0) begin
               next_cur.dp_src = 1'b0;
               if (fe.dm_high) begin
                  next_cur.state  = BC_SECONDARY;
                  next_cur.dm_src = 1'b1;
               end else begin
                  // standard port; a signature found next is reported in its own field
                  next_cur.state      = BC_PROP;
                  next_cur.port_class = PORT_SDP;
               end
               next_cur.timer = TIMER_W'(SETTLE_CYC - 1);
            end
         end
         BC_SECONDARY: begin
            if (cur.timer == '0) begin
               next_cur.dm_src     = 1'b0;
               next_cur.state      = BC_PROP;
               next_cur.port_class = fe.dp_high ? PORT_DCP : PORT_CDP;
            end
         end
         BC_PROP: begin
            next_cur.state      = BC_DONE;
            next_cur.prop_class = fe.prop_sig;
            // highest of the two classifications wins
            next_cur.dpdm_limit = max_lim(bc_limit(cur.port_class),
                                          prop_limit(fe.prop_sig));
         end
         BC_DONE: begin
            if (!fe.supply_ok) begin
               next_cur.state = BC_IDLE;
            end
         end
      endcase
      if (!dpdm_detect_enable || (!fe.supply_ok && cur.state != BC_IDLE)) begin
         next_cur.state      = BC_IDLE;
         next_cur.dp_src     = 1'b0;
         next_cur.dm_src     = 1'b0;
         next_cur.dcd_src    = 1'b0;
         next_cur.timer      = '0;
         next_cur.port_class = PORT_NONE;
         next_cur.prop_class = PROP_NONE;
         next_cur.dpdm_limit = LIM_NONE;
      end
      next_cur.done = (next_cur.state == BC_DONE);
      // a disabled or unfinished data-line detector offers nothing
      dpdm_eff = (dpdm_detect_enable && cur.state == BC_DONE) ? cur.dpdm_limit : LIM_NONE;
      // the 500 ma floor covers unknown sources and both detectors off
      next_cur.applied = max_lim(max_lim(dpdm_eff, cc_lim), LIM_500);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign dp_source_on            = cur.dp_src;
   assign dm_source_on            = cur.dm_src;
   assign dcd_current_on          = cur.dcd_src;
   assign detect_done             = cur.done;
   assign bc12_port_class_field   = cur.port_class;
   assign proprietary_class_field = cur.prop_class;
   assign usb_applied_limit_field = cur.applied;
   assign cc_current_field        = cc_lim;
   assign cc_attached             = cc_att;
   assign cc_active_line          = cc_line;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_open_timeout;
      cur.state == BC_CONTACT && cur.timer == '0 && fe.dp_high
         && dpdm_detect_enable && fe.supply_ok;
   endsequence

   sequence s_finish;
      cur.state == BC_PROP && dpdm_detect_enable && fe.supply_ok;
   endsequence

   property p_open_sdp;
      s_open_timeout |=> cur.state == BC_DONE && bc12_port_class_field == PORT_SDP;
   endproperty
   a_open_sdp: assert property (p_open_sdp) else $error("open lines not sdp");

   property p_floor;
      $past(rst_n) |-> usb_applied_limit_field >= LIM_500;
   endproperty
   a_floor: assert property (p_floor) else $error("applied limit under 500 ma");

   property p_bc_map;
      s_finish ##0 fe.prop_sig == PROP_NONE
      |=> cur.dpdm_limit == bc_limit(bc12_port_class_field);
   endproperty
   a_bc_map: assert property (p_bc_map) else $error("bc1.2 limit wrong");

   property p_prop_map;
      s_finish ##0 fe.prop_sig != PROP_NONE
      |=> cur.dpdm_limit == max_lim(bc_limit(bc12_port_class_field),
                                    prop_limit(proprietary_class_field));
   endproperty
   a_prop_map: assert property (p_prop_map) else $error("proprietary limit wrong");

   property p_disabled;
      !dpdm_detect_enable |=> cur.state == BC_IDLE && !dp_source_on && !dm_source_on
                              && !dcd_current_on && bc12_port_class_field == PORT_NONE;
   endproperty
   a_disabled: assert property (p_disabled) else $error("data lines probed while off");

   property p_max;
      $past(rst_n) |=> usb_applied_limit_field ==
         max_lim(max_lim($past(dpdm_eff), $past(cc_lim)), LIM_500);
   endproperty
   a_max: assert property (p_max) else $error("larger limit not applied");

   property p_done_applies;
      cur.state == BC_DONE && dpdm_detect_enable
      |=> usb_applied_limit_field >= $past(cur.dpdm_limit);
   endproperty
   a_done_applies: assert property (p_done_applies) else $error("detected limit not applied");

   property p_off_no_share;
      !dpdm_detect_enable ##1 !dpdm_detect_enable
      |-> usb_applied_limit_field == max_lim($past(cc_lim), LIM_500);
   endproperty
   a_off_no_share: assert property (p_off_no_share) else $error("disabled detector counted");

endmodule

// *** rtl/usb_detect_pkg.sv ***
package usb_detect_pkg;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_MHZ         = 40;
   localparam int unsigned DCD_TIMEOUT_US  = 300000;
   localparam int unsigned SETTLE_US       = 40000;
   localparam int unsigned CC_DEBOUNCE_US  = 100000;
   localparam int unsigned DCD_CYCLES      = DCD_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
   localparam int unsigned CC_DEB_CYCLES   = CC_DEBOUNCE_US * CLK_MHZ;
   localparam int unsigned TIMER_W         = 24;
   localparam int unsigned SYNC_STAGES     = 2;

   // -----------------------------------------------------------------
   // current limits, in steps of 100 ma
   // -----------------------------------------------------------------
   typedef logic [4:0] limit_t;
   localparam limit_t LIM_NONE = 5'h00;
   localparam limit_t LIM_500  = 5'h05;
   localparam limit_t LIM_1000 = 5'h0a;
   localparam limit_t LIM_1500 = 5'h0f;
   localparam limit_t LIM_2000 = 5'h14;
   localparam limit_t LIM_2400 = 5'h18;
   localparam limit_t LIM_3000 = 5'h1e;

   // -----------------------------------------------------------------
   // encodings
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PORT_NONE = 2'h0,
      PORT_SDP  = 2'h1,
      PORT_CDP  = 2'h2,
      PORT_DCP  = 2'h3
   } port_class_t;

   typedef enum logic [2:0] {
      PROP_NONE      = 3'h0,
      PROP_GENERIC   = 3'h1,
      PROP_VA_500    = 3'h2,
      PROP_VA_1000   = 3'h3,
      PROP_VA_2000   = 3'h4,
      PROP_VA_12W    = 3'h5,
      PROP_VB_2000   = 3'h6,
      PROP_OTHER     = 3'h7
   } prop_class_t;

   // advertised rp level on a cc line
   typedef enum logic [1:0] {
      CC_OPEN = 2'h0,
      CC_DEF  = 2'h1,
      CC_1A5  = 2'h2,
      CC_3A0  = 2'h3
   } cc_level_t;

   typedef enum logic [2:0] {
      BC_IDLE      = 3'b000,
      BC_CONTACT   = 3'b001,
      BC_PRIMARY   = 3'b011,
      BC_SECONDARY = 3'b010,
      BC_PROP      = 3'b110,
      BC_DONE      = 3'b111
   } bc_state_t;

   // raw levels from the analog front end
   typedef struct packed {
      logic        supply_ok;
      logic        dp_high;
      logic        dm_high;
      cc_level_t   cc1;
      cc_level_t   cc2;
      prop_class_t prop_sig;
   } front_end_t;

   // -----------------------------------------------------------------
   // decoding
   // -----------------------------------------------------------------
   function automatic limit_t bc_limit(input port_class_t c);
      unique case (c)
         PORT_CDP, PORT_DCP: bc_limit = LIM_1500;
         default:            bc_limit = LIM_500;
      endcase
   endfunction

   function automatic limit_t prop_limit(input prop_class_t p);
      unique case (p)
         PROP_NONE:                  prop_limit = LIM_NONE;
         PROP_GENERIC, PROP_VA_500:  prop_limit = LIM_500;
         PROP_VA_1000:               prop_limit = LIM_1000;
         PROP_VA_2000, PROP_VB_2000: prop_limit = LIM_2000;
         PROP_VA_12W:                prop_limit = LIM_2400;
         PROP_OTHER:                 prop_limit = LIM_3000;
      endcase
   endfunction

   function automatic limit_t cc_limit(input cc_level_t l);
      unique case (l)
         CC_OPEN: cc_limit = LIM_NONE;
         CC_DEF:  cc_limit = LIM_500;
         CC_1A5:  cc_limit = LIM_1500;
         CC_3A0:  cc_limit = LIM_3000;
      endcase
   endfunction

   function automatic limit_t max_lim(input limit_t a, input limit_t b);
      max_lim = (a > b) ? a : b;
   endfunction

endpackage

// *** tb/usb_charger_type_detect_tb.sv ***
`timescale 1ns/1ps
module usb_charger_type_detect_tb;
   import usb_detect_pkg::*;

   localparam int unsigned DEB = 10;

   logic        sys_clk;
   logic        rst_n;
   logic        en_dp;
   logic        en_cc;
   logic        plugged;
   logic        cc_line;
   logic        det_done;
   logic        dp_src;
   logic        dm_src;
   logic        dcd_on;
   logic        attached;
   logic        act_line;
   port_class_t kind;
   port_class_t cls;
   prop_class_t prop;
   prop_class_t prop_seen;
   cc_level_t   lvl;
   cc_level_t   c1;
   cc_level_t   c2;
   front_end_t  fe;
   limit_t      applied;
   limit_t      cc_cur;
   int          errors;
   int          compares;
   int          seed;

   assign c1 = cc_line ? CC_OPEN : lvl;
   assign c2 = cc_line ? lvl : CC_OPEN;

   usb_source_model src (.plugged(plugged), .kind(kind), .prop(prop), .cc1(c1), .cc2(c2),
      .dp_source_on(dp_src), .dm_source_on(dm_src), .dcd_current_on(dcd_on), .front_end(fe));

   usb_charger_type_detect #(.DCD_CYC(20), .SETTLE_CYC(8), .CC_DEB_CYC(DEB)) uut (
      .sys_clk                 (sys_clk),
      .rst_n                   (rst_n),
      .dpdm_detect_enable      (en_dp),
      .cc_detect_enable        (en_cc),
      .front_end               (fe),
      .dp_source_on            (dp_src),
      .dm_source_on            (dm_src),
      .dcd_current_on          (dcd_on),
      .detect_done             (det_done),
      .bc12_port_class_field   (cls),
      .proprietary_class_field (prop_seen),
      .usb_applied_limit_field (applied),
      .cc_current_field        (cc_cur),
      .cc_attached             (attached),
      .cc_active_line          (act_line)
   );

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic [4:0] mx(input logic [4:0] a, input logic [4:0] b);
      return (a > b) ? a : b;
   endfunction

   function automatic logic [4:0] lim_cc(input logic [1:0] l);
      case (l)
         2'h1:    return 5'h05;
         2'h2:    return 5'h0f;
         2'h3:    return 5'h1e;
         default: return 5'h00;
      endcase
   endfunction

   function automatic logic [4:0] lim_prop(input logic [2:0] p);
      case (p)
         3'h1, 3'h2: return 5'h05;
         3'h3:       return 5'h0a;
         3'h4, 3'h6: return 5'h14;
         3'h5:       return 5'h18;
         3'h7:       return 5'h1e;
         default:    return 5'h00;
      endcase
   endfunction

   // open lines time out in contact detect, so no signature is sampled
   function automatic logic [1:0] exp_cls();
      return (kind == PORT_NONE) ? 2'h1 : kind;
   endfunction

   function automatic logic [2:0] exp_prop();
      return (kind == PORT_NONE) ? 3'h0 : prop;
   endfunction

   function automatic logic [4:0] exp_dp();
      return mx((exp_cls() >= 2'h2) ? 5'h0f : 5'h05, lim_prop(exp_prop()));
   endfunction

   task automatic plug;
      cc_level_t keep;
      int        k;
      keep    = lvl;
      plugged = 1'b0;
      lvl     = CC_OPEN;
      tick(DEB + 6);
      lvl     = keep;
      plugged = 1'b1;
      for (k = 0; k < 200 && en_dp && det_done !== 1'b1; k++) begin
         tick(1);
      end
      tick(DEB + 8);
   endtask

   task automatic check_all;
      logic on;
      on = en_cc && lvl != CC_OPEN;
      check("detect_done", det_done, en_dp);
      check("sources", {dp_src, dm_src, dcd_on}, 3'h0);
      check("port_class", cls, en_dp ? exp_cls() : 2'h0);
      check("prop_class", prop_seen, en_dp ? exp_prop() : 3'h0);
      check("cc_attached", attached, on);
      if (on) check("cc_line", act_line, cc_line);
      check("cc_current", cc_cur, en_cc ? lim_cc(lvl) : 5'h00);
      check("applied", applied, mx(mx(en_dp ? exp_dp() : 5'h00, en_cc ? lim_cc(lvl) : 5'h00),
            5'h05));
   endtask

   // -----------------------------------------------------------------
   // clock, watchdog, sequence
   // -----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      tally_and_finish();
   end

   initial begin
      seed     = 32'hde60e171;
      errors   = 0;
      compares = 0;
      rst_n    = 1'b0;
      en_dp    = 1'b1;
      en_cc    = 1'b1;
      plugged  = 1'b0;
      cc_line  = 1'b0;
      kind     = PORT_NONE;
      prop     = PROP_NONE;
      lvl      = CC_OPEN;
      tick(3);
      check("applied", applied, 5'h00);
      rst_n = 1'b1;
      tick(1);
      check("applied", applied, 5'h05);
      // every class and every signature code, random cc and enables
      for (int i = 0; i < 16; i++) begin
         kind    = port_class_t'(2'(i));
         prop    = prop_class_t'(3'(i + i / 4));
         lvl     = cc_level_t'(2'($random(seed)));
         cc_line = 1'($random(seed));
         en_dp   = (i < 12) ? 1'b1 : 1'($random(seed));
         en_cc   = (i < 12) ? 1'b1 : 1'($random(seed));
         plug();
         check_all();
      end
      // live level change, both enables dropped and the cc enable restored while attached
      kind    = PORT_DCP;
      prop    = PROP_VA_12W;
      lvl     = CC_1A5;
      cc_line = 1'b1;
      en_dp   = 1'b1;
      en_cc   = 1'b1;
      plug();
      check_all();
      lvl = CC_3A0;
      tick(DEB + 6);
      check_all();
      en_cc = 1'b0;
      tick(2);
      check_all();
      en_dp = 1'b0;
      tick(2);
      check_all();
      en_cc = 1'b1;
      tick(DEB + 6);
      check_all();
      tally_and_finish();
   end
endmodule

// *** tb/usb_source_model.sv ***
`timescale 1ns/1ps
module usb_source_model
   import usb_detect_pkg::*;
(
   input  wire logic                        plugged,
   input  wire usb_detect_pkg::port_class_t kind,
   input  wire usb_detect_pkg::prop_class_t prop,
   input  wire usb_detect_pkg::cc_level_t   cc1,
   input  wire usb_detect_pkg::cc_level_t   cc2,
   input  wire logic                        dp_source_on,
   input  wire logic                        dm_source_on,
   input  wire logic                        dcd_current_on,
   output      usb_detect_pkg::front_end_t  front_end
);
   // -----------------------------------------------------------------
   // far-side port
   // -----------------------------------------------------------------
   // kind none stands for open data lines: the contact current lifts d+
   // and nothing ever pulls it down, so contact detect must time out.
   // released lines fall to the host pull-downs.
   logic open_lines;

   assign open_lines = (kind == PORT_NONE);

   always_comb begin
      front_end.supply_ok = plugged;
      front_end.dp_high   = plugged & ((dcd_current_on & open_lines) | dp_source_on |
                            (dm_source_on & (kind == PORT_DCP)));
      front_end.dm_high   = plugged & ((dp_source_on & (kind == PORT_CDP || kind == PORT_DCP))
                            | (dm_source_on & ~open_lines));
      front_end.cc1       = cc1;
      front_end.cc2       = cc2;
      front_end.prop_sig  = plugged ? prop : PROP_NONE;
   end
endmodule
